// *** htr_pkg.sv ***
package htr_pkg;

  // ---------------------------------------------------------------
  // Bus addressing and command bytes
  // ---------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h38;
  localparam logic [7:0] CMD_STATUS = 8'h71;
  localparam logic [7:0] CMD_TRIGGER = 8'hac;
  localparam logic [7:0] TRIG_PARAM1 = 8'h33;
  localparam logic [7:0] TRIG_PARAM2 = 8'h00;

  // ---------------------------------------------------------------
  // Status byte layout and read frame
  // ---------------------------------------------------------------
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_CAL_BIT = 3;
  localparam int RAW_W = 20;
  localparam logic [2:0] CRC_BYTE_IDX = 3'h6;
  localparam logic [2:0] LAST_BYTE_IDX = 3'h7;
  localparam logic [7:0] IDLE_FILL = 8'hff;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ---------------------------------------------------------------
  // Check byte
  // ---------------------------------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hff;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int POR_TIME_MS = 100;
  // Longest settling time, so the count rounds down
  localparam int POR_CYCLES = POR_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Target state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } htr_state_e;

endpackage

// *** htr_crc_if.sv ***
`timescale 1ns/10ps
interface htr_crc_if;
  logic clear;
  logic step;
  logic [7:0] data;
  logic [7:0] crc;

  // Engine side folds bytes in, user side feeds them
  modport eng (input clear, input step, input data, output crc);
  modport user (output clear, output step, output data, input crc);
endinterface

// *** htr_crc8.sv ***
`timescale 1ns/10ps
module htr_crc8
  import htr_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Byte feed and result
  htr_crc_if.eng crc_if
);

  logic [7:0] crc_reg;
  logic [7:0] crc_next;

  // ---------------------------------------------------------------
  // Whole byte per cycle, MSB first
  // ---------------------------------------------------------------
  always_comb begin
    crc_next = crc_reg ^ crc_if.data;
    for (int i = 0; i < 8; i++) begin
      if (crc_next[7]) begin
        crc_next = {crc_next[6:0], 1'b0} ^ CRC_POLY; // [RULE12] [RULE20]
      end else begin
        crc_next = {crc_next[6:0], 1'b0};
      end
    end
  end

  // Clear takes priority, a new frame always restarts from all ones
  always_ff @(posedge clock_i) begin
    if (srst_i || crc_if.clear) begin
      crc_reg <= CRC_INIT; // [RULE12]
    end else if (crc_if.step) begin
      crc_reg <= crc_next;
    end
  end

  assign crc_if.crc = crc_reg;

endmodule

// *** htr_readout.sv ***
`timescale 1ns/10ps
// How it works
// RULE1: Ready for commands within 100 ms settling.
// RULE2: Host opens each transfer with start.
// RULE3: Host closes each transfer with stop.
// RULE4: First byte: address 0x38 plus direction.
// RULE5: Acknowledge received byte after eighth falling edge.
// RULE6: Status bit 7 shows measurement busy.
// RULE7: Host fetches status with 0x71 first.
// RULE8: Host initialises if status lacks 0x18.
// RULE9: Trigger is 0xAC, then 0x33, 0x00.
// RULE10: Host waits 80 ms, polls busy, reads.
// RULE11: CRC byte follows six data bytes.
// RULE12: CRC-8, polynomial 0x31, start value 0xFF.
// RULE13: Host scales humidity by 100 over 2^20.
// RULE14: Host scales temperature 200 over 2^20, minus 50.
// RULE15: Host checks calibration only after power-on.
// RULE16: Status bit 3 shows calibrated; others reserved.
// RULE17: Data sampled on rise, changed after fall.
// RULE18: Interface static, no minimum clock rate.
// RULE19: Status, humidity, temperature, twenty bits, MSB first.
// RULE20: CRC over six bytes, MSB first, in order.
module htr_readout
  import htr_pkg::*;
#(
  parameter int unsigned POR_CYCLES_P = POR_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Serial clock pin, never driven by this end
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  // Serial data pin, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Status
  output logic ready_o,
  output logic busy_o,
  input wire logic cal_ok_i,
  // Measurement engine
  output logic meas_req_o,
  input wire logic meas_valid_i,
  input wire logic [RAW_W-1:0] hum_i,
  input wire logic [RAW_W-1:0] temp_i
);

  localparam int POR_W = $clog2(POR_CYCLES_P + 1);

  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_reg;
  logic sda_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [POR_W-1:0] por_cnt_reg;
  logic ready_reg;
  htr_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic addr_phase_reg;
  logic is_read_reg;
  logic nack_reg;
  logic [2:0] byte_idx_reg;
  logic sda_oe_reg;
  logic load_now;
  logic wr_byte_done;
  logic [7:0] tx_byte;
  logic [1:0] trig_stage_reg;
  logic busy_reg;
  logic meas_req_reg;
  logic [RAW_W-1:0] raw_humidity_value_reg;
  logic [RAW_W-1:0] raw_temp_reg;
  logic [7:0] status_byte;
  htr_crc_if crc_bus ();

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // A change counts only once the second and third stages agree,
  // which also rejects single-sample glitches on the pins.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end

  // Edges and bus conditions; nothing times out, so a host may stall
  // the clock for as long as it likes
  assign scl_rise = scl_reg & ~scl_prev_reg; // [RULE18]
  assign scl_fall = ~scl_reg & scl_prev_reg; // [RULE17]
  assign start_det = ready_reg & scl_reg & scl_prev_reg &
                     sda_prev_reg & ~sda_reg; // [RULE2]
  assign stop_det = scl_reg & scl_prev_reg &
                    ~sda_prev_reg & sda_reg; // [RULE3]

  // ---------------------------------------------------------------
  // Power-on settling
  // ---------------------------------------------------------------
  // Bus traffic is ignored until the count runs out.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      por_cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else if (!ready_reg) begin
      if (por_cnt_reg == POR_W'(POR_CYCLES_P - 1)) begin
        ready_reg <= 1'b1; // [RULE1]
      end
      por_cnt_reg <= por_cnt_reg + POR_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Read frame contents
  // ---------------------------------------------------------------
  // Reserved status bits read as zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_BUSY_BIT] = busy_reg; // [RULE6]
    status_byte[STAT_CAL_BIT] = cal_ok_i; // [RULE16]
  end

  // Byte order on a read; past the check byte the bus reads idle
  always_comb begin
    case (byte_idx_reg)
      3'h0: tx_byte = status_byte; // [RULE19]
      3'h1: tx_byte = raw_humidity_value_reg[19:12];
      3'h2: tx_byte = raw_humidity_value_reg[11:4];
      3'h3: tx_byte = {raw_humidity_value_reg[3:0], raw_temp_reg[19:16]};
      3'h4: tx_byte = raw_temp_reg[15:8];
      3'h5: tx_byte = raw_temp_reg[7:0];
      3'h6: tx_byte = crc_bus.crc; // [RULE11]
      default: tx_byte = IDLE_FILL;
    endcase
  end

  // A byte is loaded on the fall that ends an ack slot
  assign load_now = scl_fall &&
                    ((state_reg == ST_RX_ACK && is_read_reg) ||
                     (state_reg == ST_TX_ACK && !nack_reg));
  assign wr_byte_done = scl_fall && state_reg == ST_RX &&
                        bit_cnt_reg == BITS_PER_BYTE && !addr_phase_reg;

  // Check byte covers exactly what went out on the wire
  assign crc_bus.clear = start_det;
  assign crc_bus.step = load_now && byte_idx_reg < CRC_BYTE_IDX; // [RULE20]
  assign crc_bus.data = tx_byte;

  htr_crc8 u_crc (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .crc_if(crc_bus)
  );

  // ---------------------------------------------------------------
  // Target state machine
  // ---------------------------------------------------------------
  // Start restarts from any state (repeated start); stop always idles.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_phase_reg <= 1'b0;
      is_read_reg <= 1'b0;
      nack_reg <= 1'b0;
      byte_idx_reg <= 3'h0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_RX;
      bit_cnt_reg <= 4'h0;
      addr_phase_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_reg}; // [RULE17]
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            if (!addr_phase_reg) begin
              sda_oe_reg <= 1'b1; // [RULE5]
              state_reg <= ST_RX_ACK;
              if (byte_idx_reg != LAST_BYTE_IDX) begin
                byte_idx_reg <= byte_idx_reg + 3'h1;
              end
            end else if (shift_reg[7:1] == TARGET_ADDR) begin // [RULE4]
              sda_oe_reg <= 1'b1; // [RULE5]
              is_read_reg <= shift_reg[0];
              byte_idx_reg <= 3'h0;
              state_reg <= ST_RX_ACK;
            end else begin
              state_reg <= ST_IDLE; // Not ours, stay off the bus
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            addr_phase_reg <= 1'b0;
            bit_cnt_reg <= 4'h1;
            if (is_read_reg) begin
              // Status goes out now, so the next load is byte one
              byte_idx_reg <= byte_idx_reg + 3'h1; // [RULE19]
              sda_oe_reg <= ~tx_byte[7];
              shift_reg <= {tx_byte[6:0], 1'b1};
              state_reg <= ST_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_RX;
            end
          end
        end
        ST_TX: begin
          // Data changes only after a falling edge
          if (scl_fall) begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_TX_ACK;
            end else begin
              sda_oe_reg <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b1};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            nack_reg <= sda_reg;
          end else if (scl_fall) begin
            if (nack_reg) begin
              state_reg <= ST_IDLE; // [RULE11]
            end else begin
              sda_oe_reg <= ~tx_byte[7];
              shift_reg <= {tx_byte[6:0], 1'b1};
              bit_cnt_reg <= 4'h1;
              state_reg <= ST_TX;
            end
            if (byte_idx_reg != LAST_BYTE_IDX) begin
              byte_idx_reg <= byte_idx_reg + 3'h1;
            end
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Trigger command decode
  // ---------------------------------------------------------------
  // Write data bytes are numbered from 0; byte_idx_reg still holds
  // the number of the byte just received when it completes.
  always_ff @(posedge clock_i) begin
    if (srst_i || start_det) begin
      trig_stage_reg <= 2'h0;
    end else if (wr_byte_done) begin
      case (byte_idx_reg)
        3'h0: trig_stage_reg <= {1'b0, shift_reg == CMD_TRIGGER};
        3'h1: trig_stage_reg <= (trig_stage_reg == 2'h1 &&
                                 shift_reg == TRIG_PARAM1) ? 2'h2 : 2'h0;
        default: trig_stage_reg <= 2'h0;
      endcase
    end
  end

  // Busy from a full trigger sequence until the engine returns data;
  // a new trigger in the same cycle as a result keeps busy set.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy_reg <= 1'b0;
      meas_req_reg <= 1'b0;
    end else begin
      meas_req_reg <= 1'b0;
      if (wr_byte_done && byte_idx_reg == 3'h2 &&
          trig_stage_reg == 2'h2 && shift_reg == TRIG_PARAM2) begin
        busy_reg <= 1'b1; // [RULE6] [RULE9]
        meas_req_reg <= 1'b1;
      end else if (meas_valid_i) begin
        busy_reg <= 1'b0; // [RULE6]
      end
    end
  end

  // Results held until the next measurement completes
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      raw_humidity_value_reg <= '0;
      raw_temp_reg <= '0;
    end else if (meas_valid_i) begin
      raw_humidity_value_reg <= hum_i; // [RULE19]
      raw_temp_reg <= temp_i;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Clock line is left to the pull-up, so it stays high while settling
  assign scl_o = 1'b0;
  assign scl_oe_o = 1'b0; // [RULE1]
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_reg;
  assign ready_o = ready_reg;
  assign busy_o = busy_reg;
  assign meas_req_o = meas_req_reg;

endmodule

// *** htr_readout_sva.sv ***
`timescale 1ns/10ps
module htr_readout_sva #(
  parameter int unsigned POR_CYCLES_P = 20
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Bus pins
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Status and engine
  input wire logic ready_o,
  input wire logic busy_o,
  input wire logic meas_req_o,
  input wire logic meas_valid_i
);
  int unsigned por_cnt;
  // Cycles since release, saturating so it never wraps
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      por_cnt <= 0;
    end else if (por_cnt < POR_CYCLES_P + 2) begin
      por_cnt <= por_cnt + 1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_por_early:
    assert property (por_cnt < POR_CYCLES_P |-> !ready_o)
    else $error("ready came too early");
  a_por_late:
    assert property (por_cnt >= POR_CYCLES_P |-> ready_o)
    else $error("ready came too late");
  a_ready_sticky:
    assert property (ready_o |=> ready_o) else $error("ready dropped");
  a_quiet_early:
    assert property (!ready_o |-> !sda_oe_o)
    else $error("data driven before ready");
  a_scl_free:
    assert property (!scl_oe_o && !scl_o) else $error("clock driven");
  a_sda_drain:
    assert property (!sda_o) else $error("data driven high");
  a_oe_bit_hold:
    assert property ($changed(sda_oe_o) |=> $stable(sda_oe_o)[*5])
    else $error("data bit too short");
  a_trig_req:
    assert property ($rose(busy_o) |-> meas_req_o)
    else $error("no request after busy");
  a_req_busy:
    assert property (meas_req_o |-> busy_o && !$past(meas_req_o))
    else $error("request not a busy pulse");
  a_busy_done:
    assert property ($fell(busy_o) |-> $past(meas_valid_i))
    else $error("busy cleared without result");
  c_req: cover property (meas_req_o);
  c_done: cover property ($fell(busy_o));
  c_drive: cover property (ready_o && sda_oe_o);
endmodule

// *** htr_host.sv ***
`timescale 1ns/10ps
module htr_host (
  // Clock
  input wire logic clock_i,
  // Bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  int lo = 5;
  int hi = 3;
  // Idle bus: clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Data moves well after the fall; sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic r);
    w(2);
    sda_oe_o <= !b;
    w(lo - 2);
    scl_o <= 1'b1;
    w(hi);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic start();
    w(2);
    sda_oe_o <= 1'b0;
    w(2);
    scl_o <= 1'b1;
    w(hi + 2);
    sda_oe_o <= 1'b1;
    w(hi + 2);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    w(2);
    sda_oe_o <= 1'b1;
    w(lo - 2);
    scl_o <= 1'b1;
    w(hi + 2);
    sda_oe_o <= 1'b0;
    w(lo);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // Ack keeps the read going, nack ends it
  task automatic rd(input logic a, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!a, r);
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
  import htr_pkg::*;
  localparam int POR_P = 200;
  logic clock_i, srst_i, cal_ok_i, h_scl, h_oe, ak;
  logic meas_valid_i = 1'b0;
  logic [RAW_W-1:0] hum_i, temp_i;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, ready_o, busy_o, meas_req_o;
  logic [7:0] fr [8];
  int num_errors = 0;
  int cmp_count = 0;
  int eng_cnt = 0;
  // Wired levels: pull-ups win unless someone pulls low
  wire scl = h_scl && !scl_oe_o;
  wire sda = !(h_oe || sda_oe_o);
  htr_readout #(.POR_CYCLES_P(POR_P)) htr_readout_inst (
    .clock_i(clock_i), .srst_i(srst_i), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .ready_o(ready_o), .busy_o(busy_o), .cal_ok_i(cal_ok_i),
    .meas_req_o(meas_req_o), .meas_valid_i(meas_valid_i),
    .hum_i(hum_i), .temp_i(temp_i));
  htr_host host_inst (.clock_i(clock_i), .sda_i(sda), .scl_o(h_scl),
    .sda_oe_o(h_oe));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Engine answers slowly so the busy flag can be polled
  always @(posedge clock_i) begin
    if (meas_req_o === 1'b1) eng_cnt <= 400;
    else if (eng_cnt > 0) eng_cnt <= eng_cnt - 1;
    meas_valid_i <= (eng_cnt == 1);
  end
  function automatic logic [7:0] crc8(input logic [47:0] v);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Read n bytes, acking all but the last
  task automatic xfer(input logic [7:0] a, input int n);
    host_inst.start();
    host_inst.wr(a, ak);
    for (int i = 0; i < n; i++) host_inst.rd(i < n - 1, fr[i]);
    host_inst.stop();
  endtask
  task automatic wxfer(input logic [23:0] b);
    host_inst.start();
    host_inst.wr({TARGET_ADDR, 1'b0}, ak);
    cmp("write ack", 8'h01, {7'h00, ak});
    for (int i = 0; i < 3; i++) begin
      host_inst.wr(b[23 - 8 * i -: 8], ak);
      cmp("byte ack", 8'h01, {7'h00, ak});
    end
    host_inst.stop();
  endtask
  task automatic t_por();
    xfer({TARGET_ADDR, 1'b1}, 1);
    cmp("early ack", 8'h00, {7'h00, ak});
    for (int i = 0; i < POR_P && ready_o !== 1'b1; i++) @(posedge clock_i);
    cmp("ready", 8'h01, {7'h00, ready_o});
    cmp("pins", 8'h00, {5'h00, scl_o, scl_oe_o, sda_o});
  endtask
  // Status first with calibration low, then high
  task automatic t_status();
    for (int c = 0; c < 2; c++) begin
      cal_ok_i <= c[0];
      xfer({TARGET_ADDR, 1'b1}, 1);
      cmp("addr ack", 8'h01, {7'h00, ak});
      cmp("status", {4'h0, c[0], 3'h0}, fr[0]);
      if ((fr[0] & 8'h18) != 8'h18) wxfer({8'h1b, 8'h00, 8'h00});
    end
  endtask
  task automatic t_bad_addr();
    xfer({TARGET_ADDR ^ 7'h01, 1'b1}, 1);
    cmp("foreign ack", 8'h00, {7'h00, ak});
    cmp("foreign data", IDLE_FILL, fr[0]);
  endtask
  task automatic t_bad_cmd();
    wxfer({CMD_TRIGGER, 8'h34, TRIG_PARAM2});
    cmp("no start", 8'h00, {7'h00, busy_o});
  endtask
  // Trigger, poll busy, read the full frame with check byte
  task automatic t_trigger(input logic [19:0] h, input logic [19:0] t);
    logic [47:0] v;
    logic [19:0] rh, tc;
    hum_i <= h;
    temp_i <= t;
    wxfer({CMD_TRIGGER, TRIG_PARAM1, TRIG_PARAM2});
    cmp("busy", 8'h01, {7'h00, busy_o});
    xfer({TARGET_ADDR, 1'b1}, 1);
    cmp("busy bit", 8'h88, fr[0]);
    for (int i = 0; i < 20 && fr[0][7] !== 1'b0; i++) begin
      xfer({TARGET_ADDR, 1'b1}, 1);
    end
    xfer({TARGET_ADDR, 1'b1}, 8);
    v = {8'h08, h, t};
    for (int i = 0; i < 6; i++) begin
      cmp("frame", v[47 - 8 * i -: 8], fr[i]);
    end
    cmp("crc", crc8(v), fr[6]);
    // Host scaling, whole units, from the raw fields as received
    rh = {fr[1], fr[2], fr[3][7:4]};
    tc = {fr[3][3:0], fr[4], fr[5]};
    cmp("rh", 8'(h * 100 >> 20), 8'(rh * 100 >> 20));
    cmp("degc", 8'((t*200 >> 20) - 50), 8'((tc*200 >> 20) - 50));
    cmp("past crc", IDLE_FILL, fr[7]);
  endtask
  // Stretched clock, then nack ends the read early
  task automatic t_slow();
    host_inst.lo = 24;
    host_inst.hi = 24;
    host_inst.start();
    host_inst.wr({TARGET_ADDR, 1'b1}, ak);
    host_inst.rd(1'b0, fr[0]);
    host_inst.rd(1'b0, fr[1]);
    host_inst.stop();
    host_inst.lo = 5;
    host_inst.hi = 3;
    cmp("slow status", 8'h08, fr[0]);
    cmp("after nack", IDLE_FILL, fr[1]);
  endtask
  initial begin
    srst_i = 1'b1;
    cal_ok_i = 1'b1;
    hum_i = '0;
    temp_i = '0;
    repeat (10) @(posedge clock_i);
    srst_i <= 1'b0;
    t_por();
    t_status();
    t_bad_addr();
    t_bad_cmd();
    t_trigger(20'h8a5c3, 20'h6147e);
    t_trigger(20'h0f00d, 20'hfffff);
    t_slow();
    close_out();
  end
  // Run needs about 6k cycles; cut a hang well beyond that
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule
bind htr_readout htr_readout_sva #(.POR_CYCLES_P(POR_CYCLES_P)) sva_inst (
  .clock_i(clock_i), .srst_i(srst_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .ready_o(ready_o), .busy_o(busy_o),
  .meas_req_o(meas_req_o), .meas_valid_i(meas_valid_i));
